// ==== rtl/lsc_pkg.sv ====
package lsc_pkg;

    // ----------------------------------------------------------------
    // Register offsets on the serial bus
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_MASK  = 8'h04;
    localparam logic [7:0] OFS_TRIP  = 8'h05;
    localparam logic [7:0] OFS_ICUR  = 8'h06;
    localparam logic [7:0] OFS_ITIM  = 8'h07;
    localparam logic [7:0] OFS_VOLT  = 8'h08;
    localparam logic [7:0] OFS_TAG   = 8'h09;
    localparam logic [7:0] OFS_XTRIP = 8'h0e;
    localparam logic [7:0] OFS_SLEW  = 8'h0f;
    localparam int         NUM_REGS  = 16;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_MASK = 8'hf7;
    localparam logic [7:0] RST_TRIP = 8'h30;
    localparam logic [7:0] RST_SLEW = 8'h02;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int TRIP_FINE_LSB  = 4;
    localparam int TRIP_SRC_BIT   = 3;
    localparam int TRIP_LVL_LSB   = 0;
    localparam int ICUR_LSB       = 0;
    localparam int TIM_WIDTH_LSB  = 4;
    localparam int TIM_DUTY_LSB   = 0;
    localparam int XTRIP_LSB      = 0;
    localparam int SLEW_LSB       = 0;
    localparam int MASK_STS_LSB   = 4;
    localparam int MASK_FLG_LSB   = 0;

    // ----------------------------------------------------------------
    // Serial framing
    // ----------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    // Bus address value is arbitrary
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;
    localparam int         SYNC_W       = 6;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_ADDR  = 7'b0000010,
        ST_AACK  = 7'b0000100,
        ST_WBYTE = 7'b0001000,
        ST_WACK  = 7'b0010000,
        ST_RBYTE = 7'b0100000,
        ST_RACK  = 7'b1000000
    } lsc_st_t;

    typedef struct packed {
        logic input_above_lockout_status;
        logic input_below_tag_status;
        logic detect_timer_expired_status;
        logic switch_on_status;
    } lsc_status_t;

    typedef struct packed {
        logic overvoltage_flag;
        logic short_circuit_flag;
        logic overtemp_flag;
    } lsc_flag_t;

    typedef struct packed {
        logic [2:0] trip_fine_tune;
        logic       trip_source_select;
        logic [1:0] trip_level_select;
        logic [3:0] detect_current_level;
        logic [3:0] detect_pulse_width;
        logic [3:0] detect_duty;
        logic [7:0] input_tag_code;
        logic [1:0] extra_trip_level;
        logic [2:0] slew_tune_field;
    } lsc_cfg_t;

    typedef struct packed {
        lsc_st_t                   st;
        logic [3:0]                bitcnt;
        logic [7:0]                shreg;
        logic [7:0]                ptr;
        logic                      have_ptr;
        logic                      rw;
        logic                      nack;
        logic                      sda_drv;
        logic                      scl_d;
        logic                      sda_d;
        logic                      irq;
        logic [NUM_REGS-1:0][7:0]  regs;
    } lsc_state_t;

endpackage

// ==== rtl/lsc_sync.sv ====
`timescale 1ns/1ps
module lsc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic         ce_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    // ----------------------------------------------------------------
    // Two flops per bit; first stage feeds only the second
    // ----------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_reg;
        logic hold_reg;
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                meta_reg <= 1'b0;
                hold_reg <= 1'b0;
            end else if (ce_i) begin
                meta_reg <= d_i[i];
                hold_reg <= meta_reg;
            end
        end
        assign q_o[i] = hold_reg;
    end
endmodule // lsc_sync

// ==== rtl/lsc_regs.sv ====
// Function
// - One mask bit per source, one passes
// - Mask resets all ones, bit three zero
// - Bit three picks divider pin or register
// - Fine tune bits six to four, reset three
// - Threshold select bits one to zero, zero
// - Detect current bits three to zero
// - Pulse width bits seven to four
// - Detect duty bits three to zero
// - Read-only input voltage code, reset zero
// - Extra trip level bits one to zero
// - Slew tune bits two to zero, reset two
// - Interrupt pin low when an unmasked source is set
`timescale 1ns/1ps
module lsc_regs #(
    parameter logic [6:0] DEV_ADDR = lsc_pkg::DEV_ADDR_DEF
) (
    // Clock, reset, enable
    input  wire logic                 CLK_I,
    input  wire logic                 RESET_I,
    input  wire logic                 CE_I,
    // Two-wire serial pins
    input  wire logic                 SCL_I,
    input  wire logic                 SDA_I,
    output logic                      SDA_O,
    output logic                      SDA_OE_O,
    // Interrupt sources and converter result
    input  wire lsc_pkg::lsc_status_t STATUS_I,
    input  wire lsc_pkg::lsc_flag_t   FLAG_I,
    input  wire logic [7:0]           VOLT_CODE_I,
    // Configuration and interrupt
    output lsc_pkg::lsc_cfg_t         CFG_O,
    output logic                      INT_N_O
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [lsc_pkg::SYNC_W-1:0] sync_q;
    logic                       scl;
    logic                       sda;
    lsc_pkg::lsc_status_t       status_s;

    lsc_sync #(.W(lsc_pkg::SYNC_W)) u_sync (
        .clk_i   (CLK_I),
        .reset_i (RESET_I),
        .ce_i    (CE_I),
        .d_i     ({SCL_I, SDA_I, STATUS_I}),
        .q_o     (sync_q)
    );
    assign scl      = sync_q[5];
    assign sda      = sync_q[4];
    assign status_s = sync_q[3:0];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    lsc_pkg::lsc_state_t r_reg;
    lsc_pkg::lsc_state_t r_next;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic [7:0] rdata;
    logic [7:0] irq_src;

    assign scl_rise   = scl & ~r_reg.scl_d;
    assign scl_fall   = ~scl & r_reg.scl_d;
    assign start_cond = scl & r_reg.scl_d & r_reg.sda_d & ~sda;
    assign stop_cond  = scl & r_reg.scl_d & ~r_reg.sda_d & sda;

    // Sources sit in the same bit places as their mask bits
    assign irq_src = {status_s, 1'b0, FLAG_I};

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    function automatic logic readable(input logic [7:0] a);
        readable = (a == lsc_pkg::OFS_MASK)  || (a == lsc_pkg::OFS_TRIP) ||
                   (a == lsc_pkg::OFS_ICUR)  || (a == lsc_pkg::OFS_ITIM) ||
                   (a == lsc_pkg::OFS_VOLT)  || (a == lsc_pkg::OFS_TAG)  ||
                   (a == lsc_pkg::OFS_XTRIP) || (a == lsc_pkg::OFS_SLEW);
    endfunction

    // Offsets outside this bank read zero
    always_comb begin
        rdata = 8'h00;
        if (readable(r_reg.ptr)) begin
            rdata = r_reg.regs[r_reg.ptr[3:0]];
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        r_next       = r_reg;
        r_next.scl_d = scl;
        r_next.sda_d = sda;
        // Converter code is refreshed every cycle CE_I is high, never written by host
        r_next.regs[lsc_pkg::OFS_VOLT[3:0]] = VOLT_CODE_I;
        // Any unmasked source, flags included, pulls the pin low
        r_next.irq = |(irq_src & r_reg.regs[lsc_pkg::OFS_MASK[3:0]]);

        if (start_cond) begin
            r_next.st       = lsc_pkg::ST_ADDR;
            r_next.bitcnt   = 4'h0;
            r_next.sda_drv  = 1'b0;
            r_next.have_ptr = 1'b0;
        end else if (stop_cond) begin
            r_next.st      = lsc_pkg::ST_IDLE;
            r_next.sda_drv = 1'b0;
        end else begin
            unique case (r_reg.st)
                lsc_pkg::ST_IDLE: begin
                    r_next.sda_drv = 1'b0;
                end
                lsc_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        r_next.shreg  = {r_reg.shreg[6:0], sda};
                        r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    end else if (scl_fall && r_reg.bitcnt == lsc_pkg::BYTE_BITS) begin
                        r_next.bitcnt = 4'h0;
                        if (r_reg.shreg[7:1] == DEV_ADDR) begin
                            r_next.rw      = r_reg.shreg[0];
                            r_next.sda_drv = 1'b1;
                            r_next.st      = lsc_pkg::ST_AACK;
                        end else begin
                            r_next.st = lsc_pkg::ST_IDLE;
                        end
                    end
                end
                lsc_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        if (r_reg.rw) begin
                            r_next.shreg   = rdata;
                            r_next.sda_drv = ~rdata[7];
                            r_next.st      = lsc_pkg::ST_RBYTE;
                        end else begin
                            r_next.sda_drv = 1'b0;
                            r_next.st      = lsc_pkg::ST_WBYTE;
                        end
                    end
                end
                lsc_pkg::ST_WBYTE: begin
                    if (scl_rise) begin
                        r_next.shreg  = {r_reg.shreg[6:0], sda};
                        r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    end else if (scl_fall && r_reg.bitcnt == lsc_pkg::BYTE_BITS) begin
                        r_next.bitcnt  = 4'h0;
                        r_next.sda_drv = 1'b1;
                        r_next.st      = lsc_pkg::ST_WACK;
                        if (!r_reg.have_ptr) begin
                            r_next.ptr      = r_reg.shreg;
                            r_next.have_ptr = 1'b1;
                        end else begin
                            // Read-only code and foreign offsets ignore writes
                            if (readable(r_reg.ptr) && r_reg.ptr != lsc_pkg::OFS_VOLT) begin
                                r_next.regs[r_reg.ptr[3:0]] = r_reg.shreg;
                            end
                            r_next.ptr = r_reg.ptr + 8'h01;
                        end
                    end
                end
                lsc_pkg::ST_WACK: begin
                    if (scl_fall) begin
                        r_next.sda_drv = 1'b0;
                        r_next.st      = lsc_pkg::ST_WBYTE;
                    end
                end
                lsc_pkg::ST_RBYTE: begin
                    if (scl_rise) begin
                        r_next.bitcnt = r_reg.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (r_reg.bitcnt == lsc_pkg::BYTE_BITS) begin
                            r_next.bitcnt  = 4'h0;
                            r_next.sda_drv = 1'b0;
                            r_next.ptr     = r_reg.ptr + 8'h01;
                            r_next.st      = lsc_pkg::ST_RACK;
                        end else begin
                            r_next.shreg   = {r_reg.shreg[6:0], 1'b0};
                            r_next.sda_drv = ~r_reg.shreg[6];
                        end
                    end
                end
                lsc_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        r_next.nack = sda;
                    end else if (scl_fall) begin
                        if (r_reg.nack) begin
                            r_next.st = lsc_pkg::ST_IDLE;
                        end else begin
                            r_next.shreg   = rdata;
                            r_next.sda_drv = ~rdata[7];
                            r_next.st      = lsc_pkg::ST_RBYTE;
                        end
                    end
                end
                default: begin
                    r_next.st      = lsc_pkg::ST_IDLE;
                    r_next.sda_drv = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            r_reg          <= '0;
            r_reg.st       <= lsc_pkg::ST_IDLE;
            // Match the synchroniser's reset output, so no false start or stop follows reset
            r_reg.scl_d    <= 1'b0;
            r_reg.sda_d    <= 1'b0;
            r_reg.regs[lsc_pkg::OFS_MASK[3:0]] <= lsc_pkg::RST_MASK;
            r_reg.regs[lsc_pkg::OFS_TRIP[3:0]] <= lsc_pkg::RST_TRIP;
            r_reg.regs[lsc_pkg::OFS_SLEW[3:0]] <= lsc_pkg::RST_SLEW;
        end else if (CE_I) begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic [7:0] trip_b;
    logic [7:0] icur_b;
    logic [7:0] itim_b;
    logic [7:0] xtrip_b;
    logic [7:0] slew_b;

    assign trip_b  = r_reg.regs[lsc_pkg::OFS_TRIP[3:0]];
    assign icur_b  = r_reg.regs[lsc_pkg::OFS_ICUR[3:0]];
    assign itim_b  = r_reg.regs[lsc_pkg::OFS_ITIM[3:0]];
    assign xtrip_b = r_reg.regs[lsc_pkg::OFS_XTRIP[3:0]];
    assign slew_b  = r_reg.regs[lsc_pkg::OFS_SLEW[3:0]];

    assign CFG_O.trip_fine_tune       = trip_b[lsc_pkg::TRIP_FINE_LSB +: 3];
    assign CFG_O.trip_source_select   = trip_b[lsc_pkg::TRIP_SRC_BIT];
    assign CFG_O.trip_level_select    = trip_b[lsc_pkg::TRIP_LVL_LSB +: 2];
    assign CFG_O.detect_current_level = icur_b[lsc_pkg::ICUR_LSB +: 4];
    assign CFG_O.detect_pulse_width   = itim_b[lsc_pkg::TIM_WIDTH_LSB +: 4];
    assign CFG_O.detect_duty          = itim_b[lsc_pkg::TIM_DUTY_LSB +: 4];
    assign CFG_O.input_tag_code       = r_reg.regs[lsc_pkg::OFS_TAG[3:0]];
    assign CFG_O.extra_trip_level     = xtrip_b[lsc_pkg::XTRIP_LSB +: 2];
    assign CFG_O.slew_tune_field      = slew_b[lsc_pkg::SLEW_LSB +: 3];

    // Open drain: only ever pull low
    assign SDA_O    = 1'b0;
    assign SDA_OE_O = r_reg.sda_drv;
    assign INT_N_O  = ~r_reg.irq;

endmodule // lsc_regs

// ==== tb/lsc_properties.sv ====
`timescale 1ns/1ps
module lsc_props (
    // Clock and reset
    input wire logic                 CLK_I,
    input wire logic                 RESET_I,
    // Watched ports
    input wire logic                 CE_I,
    input wire logic                 SCL_I,
    input wire logic                 SDA_I,
    input wire logic                 SDA_O,
    input wire logic                 SDA_OE_O,
    input wire lsc_pkg::lsc_status_t STATUS_I,
    input wire lsc_pkg::lsc_flag_t   FLAG_I,
    input wire logic [7:0]           VOLT_CODE_I,
    input wire lsc_pkg::lsc_cfg_t    CFG_O,
    input wire logic                 INT_N_O
);
    localparam lsc_pkg::lsc_cfg_t CFG_RST = {3'h3, 1'b0, 2'h0, 12'h000, 8'h00, 2'h0, 3'h2};
    logic [3:0] age_reg;
    logic [3:0] quiet_reg;
    logic       acked_reg;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    // ------------------------------------------------
    // Age since reset, since a source moved, any answer
    // ------------------------------------------------
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            age_reg   <= 4'h0;
            quiet_reg <= 4'h0;
            acked_reg <= 1'b0;
        end else begin
            age_reg   <= (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
            quiet_reg <= ($changed(FLAG_I) || $changed(STATUS_I) || SDA_OE_O) ? 4'h0 :
                         (quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1;
            acked_reg <= acked_reg | SDA_OE_O;
        end
    end
    cfg_reset_value_a: assert property ($fell(RESET_I) |-> CFG_O == CFG_RST)
        else $error("config not at reset value");
    reset_idle_a: assert property ($fell(RESET_I) |-> INT_N_O && !SDA_OE_O)
        else $error("pins not idle after reset");
    int_source_a: assert property (!INT_N_O |-> $past(FLAG_I) != 3'h0 || $past(STATUS_I, 3) != 4'h0)
        else $error("interrupt without a source");
    int_quiet_a: assert property (quiet_reg >= 4'h5 |-> $stable(INT_N_O))
        else $error("interrupt moved while sources quiet");
    mask_default_a: assert property (age_reg >= 4'h4 && !acked_reg &&
        ($past(FLAG_I) != 3'h0 || $past(STATUS_I, 3) != 4'h0) |-> !INT_N_O)
        else $error("default mask blocked a source");
    cfg_on_ack_a: assert property (!$stable(CFG_O) |-> $rose(SDA_OE_O))
        else $error("config changed outside a write");
    ack_timing_a: assert property ($changed(SDA_OE_O) |-> !$past(SCL_I, 3) && $past(SCL_I, 4))
        else $error("data pin moved off the clock fall");
    open_drain_a: assert property (SDA_O == 1'b0)
        else $error("data pin driven high");
endmodule // lsc_props

bind lsc_regs lsc_props u_props (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .STATUS_I(STATUS_I), .FLAG_I(FLAG_I),
    .VOLT_CODE_I(VOLT_CODE_I), .CFG_O(CFG_O), .INT_N_O(INT_N_O)
);

// ==== tb/lsc_host.sv ====
`timescale 1ns/1ps
module lsc_host #(
    parameter int H = 6
) (
    // Clock and bus level
    input  wire logic clk_i,
    input  wire logic sda_i,
    // Pulls, high = line held low
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
    end
    // ------------------------------------------------
    // Data moves two cycles after the clock fall, so the
    // device never sees clock and data move together
    // ------------------------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic start();
        wt(2);
        sda_oe_o = 1'b0;
        wt(H);
        scl_oe_o = 1'b0;
        wt(H);
        sda_oe_o = 1'b1;
        wt(H);
        scl_oe_o = 1'b1;
    endtask
    task automatic stop();
        wt(2);
        sda_oe_o = 1'b1;
        wt(H);
        scl_oe_o = 1'b0;
        wt(H);
        sda_oe_o = 1'b0;
        wt(H);
    endtask
    task automatic bitx(input logic b, output logic r);
        wt(2);
        sda_oe_o = ~b;
        wt(H);
        scl_oe_o = 1'b0;
        wt(H);
        r = sda_i;
        scl_oe_o = 1'b1;
    endtask
    task automatic xfer(input logic [7:0] w, input logic ai, output logic [7:0] r, output logic ao);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bitx(w[i], b);
            r = {r[6:0], b};
        end
        bitx(ai, ao);
    endtask
    task automatic write(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic [2:0] k;
        start();
        xfer({dev, 1'b0}, 1'b1, r, k[0]);
        xfer(a, 1'b1, r, k[1]);
        xfer(d, 1'b1, r, k[2]);
        stop();
        ok = (k == 3'h0);
    endtask
    task automatic read(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic [3:0] k;
        start();
        xfer({dev, 1'b0}, 1'b1, r, k[0]);
        xfer(a, 1'b1, r, k[1]);
        start();
        xfer({dev, 1'b1}, 1'b1, r, k[2]);
        xfer(8'hff, 1'b1, d, k[3]);
        stop();
        ok = (k[2:0] == 3'h0);
    endtask
endmodule // lsc_host

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb;
    localparam logic [6:0] DEV = lsc_pkg::DEV_ADDR_DEF;
    logic                 clk;
    logic                 rst;
    lsc_pkg::lsc_status_t sts;
    lsc_pkg::lsc_flag_t   flg;
    logic [7:0]           volt;
    logic                 ce;
    lsc_pkg::lsc_cfg_t    cfg;
    logic                 int_n;
    logic                 dev_oe;
    logic                 dev_sda;
    logic                 scl_oe;
    logic                 sda_oe;
    wire                  scl = ~scl_oe;
    wire                  sda = ~(sda_oe | (dev_oe & ~dev_sda));
    int                   err_total = 0;
    int                   n_tests = 0;
    int                   seed = 66760;
    int                   cycles = 0;
    logic [7:0]           regs [16];
    logic [7:0]           m;
    logic [7:0]           s;
    logic [7:0]           rd;
    logic                 ok;
    logic [15:0]          cor [4] = '{16'h085a, 16'h0508, 16'h0bff, 16'h30a5};
    lsc_regs #(.DEV_ADDR(DEV)) dut (
        .CLK_I(clk), .RESET_I(rst), .CE_I(ce), .SCL_I(scl), .SDA_I(sda), .SDA_O(dev_sda),
        .SDA_OE_O(dev_oe), .STATUS_I(sts), .FLAG_I(flg), .VOLT_CODE_I(volt), .CFG_O(cfg), .INT_N_O(int_n)
    );
    lsc_host host (.clk_i(clk), .sda_i(sda), .scl_oe_o(scl_oe), .sda_oe_o(sda_oe));
    function automatic lsc_pkg::lsc_cfg_t cfg_exp();
        return {regs[5][6:4], regs[5][3], regs[5][1:0], regs[6][3:0], regs[7], regs[9], regs[14][1:0], regs[15][2:0]};
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        return (a == 8'h08) ? volt : (a < 8'h10) ? regs[a[3:0]] : 8'h00;
    endfunction
    function automatic logic [7:0] tag_code(input real v);
        return 8'(int'(v / 2.7 * 256.0));
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset();
        rst = 1'b1;
        cyc(16);
        rst = 1'b0;
        foreach (regs[i]) regs[i] = 8'h00;
        regs[4] = 8'hf7;
        regs[5] = 8'h30;
        regs[15] = 8'h02;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write(DEV, a, d, ok);
        `CHK(ok, 1'b1)
        if (a inside {8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0e, 8'h0f})
            regs[a[3:0]] = d;
        `CHK(cfg, cfg_exp())
    endtask
    task automatic rd_chk(input logic [7:0] a);
        host.read(DEV, a, rd, ok);
        `CHK(ok, 1'b1)
        `CHK(rd, exp_rd(a))
    endtask
    task automatic end_of_test();
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // A hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            $display("unexpected at %0t: timeout", $time);
            end_of_test();
        end
    end
    initial begin
        ce = 1'b1;
        sts = 4'h0;
        flg = 3'b010;
        volt = 8'h00;
        do_reset();
        cyc(6);
        `CHK(int_n, 1'b0)
        `CHK(cfg, cfg_exp())
        flg = 3'h0;
        cyc(4);
        `CHK(int_n, 1'b1)
        wr(lsc_pkg::OFS_TAG, tag_code(1.35));
        `CHK(cfg.input_tag_code, 8'h80)
        // Corners first: read-only code, source select, reserved, unmapped
        for (int i = 0; i < 28; i++) begin
            volt = 8'($random(seed));
            m = (i < 4) ? cor[i][15:8] : {4'h0, 4'($random(seed))};
            s = (i < 4) ? cor[i][7:0] : 8'($random(seed));
            wr(m, s);
            rd_chk(m);
        end
        for (int k = 0; k < 16; k++) begin
            m = (k < 8) ? 8'h01 << k : 8'($random(seed));
            wr(lsc_pkg::OFS_MASK, m);
            for (int j = 0; j < 8; j++) begin
                s = (k < 8) ? 8'h01 << j : 8'($random(seed));
                sts = s[7:4];
                flg = s[2:0];
                cyc(5);
                `CHK(int_n, ~|(s & m & 8'hf7))
            end
        end
        sts = 4'h0;
        flg = 3'h0;
        // Clock enable low must freeze the interrupt register
        wr(lsc_pkg::OFS_MASK, 8'hff);
        ce = 1'b0;
        flg = 3'b100;
        cyc(4);
        `CHK(int_n, 1'b1)
        flg = 3'h0;
        cyc(1);
        ce = 1'b1;
        host.write(DEV ^ 7'h01, lsc_pkg::OFS_SLEW, 8'h05, ok);
        `CHK(ok, 1'b0)
        `CHK(cfg, cfg_exp())
        volt = 8'($random(seed));
        do_reset();
        for (int a = 0; a < 17; a++)
            rd_chk(8'(a));
        end_of_test();
    end
endmodule // tb
